// ==== design/fir_pkg.sv ====
package fir_pkg;

    // Internal address map of the filter stage.
    localparam logic [9:0] ADDR_COEF_BASE   = 10'h000;
    localparam logic [9:0] ADDR_COEF_LAST   = 10'h0ff;
    localparam logic [9:0] ADDR_DATA_BASE   = 10'h100;
    localparam logic [9:0] ADDR_DATA_LAST   = 10'h1ff;
    localparam logic [9:0] ADDR_MODE        = 10'h300;
    localparam logic [9:0] ADDR_DECIM       = 10'h30a;
    localparam logic [9:0] ADDR_COEF_OFFSET = 10'h30b;
    localparam logic [9:0] ADDR_TAP_COUNT   = 10'h30c;

    // Field positions and widths.
    localparam int MODE_DUAL_BIT = 1;
    localparam int SAMPLE_W      = 18;
    localparam int COEF_W        = 20;
    localparam int DATA_W        = 36;
    localparam int PROD_W        = 38;
    localparam int HEADROOM_W    = 3;
    localparam int ACC_W         = 41;
    localparam int OUT_W         = 23;
    localparam int DEPTH         = 256;
    localparam int ADDR_W        = 8;
    localparam int HOST_W        = 36;

    // Reset values.
    localparam logic [7:0] MODE_RESET       = 8'h00;
    localparam logic [4:0] DECIM_RESET      = 5'h00;
    localparam logic [7:0] COEF_OFS_RESET   = 8'h00;
    localparam logic [7:0] TAP_COUNT_RESET  = 8'h00;

    // Pipeline depth from address issue to accumulate, and the output buffer size.
    localparam int RAM_LATENCY  = 1;
    localparam int OUT_FIFO_DEP = 2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_DRAIN = 3'b100
    } fir_state_t;

endpackage : fir_pkg

// ==== design/fir_ram.sv ====
`timescale 1ns/10ps
`default_nettype none

module fir_ram #(
    parameter int WIDTH = 20
) (
    // Clock
    input  wire logic             sys_clk_i,
    // Write port
    input  wire logic             wr_en_i,
    input  wire logic [7:0]       wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input  wire logic [7:0]       rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem [256];

    // Contents are not reset; software clears them at start-up.
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule : fir_ram

`default_nettype wire

// ==== design/fir_stage.sv ====
`timescale 1ns/10ps
`default_nettype none

module fir_stage
    import fir_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    // Samples from the comb decimator
    input  wire logic                in_valid_i,
    output logic                     in_ready_o,
    input  wire logic [SAMPLE_W-1:0] in_i_i,
    input  wire logic [SAMPLE_W-1:0] in_q_i,
    // Filter results
    output logic                     out_valid_o,
    input  wire logic                out_ready_i,
    output logic      [OUT_W-1:0]    out_i_o,
    output logic      [OUT_W-1:0]    out_q_o,
    // Internal register port
    input  wire logic [9:0]          host_addr_i,
    input  wire logic                host_wr_i,
    input  wire logic                host_rd_i,
    input  wire logic [HOST_W-1:0]   host_wdata_i,
    output logic                     host_ready_o,
    output logic                     host_rvalid_o,
    output logic      [HOST_W-1:0]   host_rdata_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Advance a circular pointer, wrapping at the live buffer length.
    function automatic logic [7:0] wrap_add(input logic [7:0] ptr, input logic [8:0] step,
                                            input logic [8:0] len);
        logic [9:0] sum;
        sum = {2'b00, ptr} + {1'b0, step};
        if (sum >= {1'b0, len}) begin
            sum = sum - {1'b0, len};
        end
        return sum[7:0];
    endfunction : wrap_add

    // Sign-extend a product into the accumulator width.
    function automatic logic signed [ACC_W-1:0] widen(input logic signed [PROD_W-1:0] p);
        return {{HEADROOM_W{p[PROD_W-1]}}, p};
    endfunction : widen

    // Configuration registers.
    logic [7:0] mode_ff;
    logic [4:0] decim_ff;
    logic [7:0] coef_ofs_ff;
    logic [7:0] tap_count_minus_one_ff;

    // Datapath state.
    fir_state_t           state_ff;
    logic [7:0]           wr_ptr_ff;
    logic [4:0]           dcnt_ff;
    logic                 pending_ff;
    logic [7:0]           tap_ff;
    logic [7:0]           coef_addr_ff;
    logic [7:0]           data_addr_ff;
    logic                 mac_ff;
    logic                 last_ff;
    logic                 push_ff;
    logic signed [ACC_W-1:0] acc_i_ff;
    logic signed [ACC_W-1:0] acc_q_ff;

    // Output buffer and host read pipeline.
    logic [1:0]       fcnt_ff;
    logic [OUT_W-1:0] head_i_ff;
    logic [OUT_W-1:0] head_q_ff;
    logic [OUT_W-1:0] tail_i_ff;
    logic [OUT_W-1:0] tail_q_ff;
    logic [1:0]       rd_stage_ff;
    logic [9:0]       rd_addr_ff;

    // Memory ports.
    logic [COEF_W-1:0] coef_q;
    logic [DATA_W-1:0] data_q;

    wire       dual          = mode_ff[MODE_DUAL_BIT];
    wire [8:0] channel_count = dual ? 9'h002 : 9'h001;
    wire [8:0] tap_count     = {1'b0, tap_count_minus_one_ff} + 9'h001;
    wire [9:0] used_raw      = dual ? {tap_count, 1'b0} : {1'b0, tap_count};
    wire [9:0] used_even     = used_raw + {9'h000, used_raw[0]};
    // Only these locations form the circular buffer.
    wire [8:0] buf_len       = (used_even > 10'h100) ? 9'h100 : used_even[8:0];
    wire [8:0] span          = (used_raw > 10'h100) ? 9'h100 : used_raw[8:0];
    wire [7:0] oldest        = wrap_add(wr_ptr_ff, (buf_len - span) & 9'h1ff, buf_len);
    // A ratio lowered mid-phase still ends the phase instead of running to wrap.
    wire       phase_end     = dcnt_ff >= decim_ff;

    wire       in_data_rg = host_addr_i[9:8] == ADDR_DATA_BASE[9:8];
    wire       in_coef_rg = host_addr_i[9:8] == ADDR_COEF_BASE[9:8];
    wire       host_mem   = host_rd_i && (in_data_rg || in_coef_rg);
    wire       accept     = in_valid_i && in_ready_o;
    wire       start      = (state_ff == ST_IDLE) && pending_ff && (fcnt_ff != 2'd2);
    wire       pop        = out_valid_o && out_ready_i;
    wire       run_last   = (state_ff == ST_RUN) && (tap_ff == tap_count_minus_one_ff);
    wire       host_take  = host_ready_o && (host_rd_i || host_wr_i);

    // A host data write owns the data write port and holds samples off.
    assign in_ready_o   = !pending_ff && !(host_wr_i && in_data_rg);
    assign host_ready_o = !host_mem || ((state_ff == ST_IDLE) && !start);
    assign out_valid_o  = fcnt_ff != 2'd0;
    assign out_i_o      = head_i_ff;
    assign out_q_o      = head_q_ff;
    assign host_rvalid_o = rd_stage_ff[1];

    wire       data_we    = accept || (host_wr_i && in_data_rg);
    wire [7:0] data_wa    = accept ? wr_ptr_ff : host_addr_i[7:0];
    wire [DATA_W-1:0] data_wd = accept ? {in_q_i, in_i_i} : host_wdata_i[DATA_W-1:0];
    wire       coef_we    = host_wr_i && in_coef_rg;
    wire [7:0] coef_ra    = (state_ff == ST_RUN) ? coef_addr_ff : host_addr_i[7:0];
    wire [7:0] data_ra    = (state_ff == ST_RUN) ? data_addr_ff : host_addr_i[7:0];

    fir_ram #(.WIDTH(COEF_W)) u_coef_ram (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (coef_we),
        .wr_addr_i (host_addr_i[7:0]),
        .wr_data_i (host_wdata_i[COEF_W-1:0]),
        .rd_addr_i (coef_ra),
        .rd_data_o (coef_q)
    );

    fir_ram #(.WIDTH(DATA_W)) u_data_ram (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (data_we),
        .wr_addr_i (data_wa),
        .wr_data_i (data_wd),
        .rd_addr_i (data_ra),
        .rd_data_o (data_q)
    );

    // One shared coefficient feeds both multipliers; any sign pattern is accepted.
    wire signed [COEF_W-1:0]   coef_s = coef_q;
    wire signed [SAMPLE_W-1:0] smp_i  = data_q[SAMPLE_W-1:0];
    wire signed [SAMPLE_W-1:0] smp_q  = data_q[DATA_W-1:SAMPLE_W];
    wire signed [PROD_W-1:0]   prod_i = coef_s * smp_i;
    wire signed [PROD_W-1:0]   prod_q = coef_s * smp_q;

    // Configuration writes; the offset takes effect at the next computation.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_ff     <= MODE_RESET;
            decim_ff    <= DECIM_RESET;
            coef_ofs_ff <= COEF_OFS_RESET;
            tap_count_minus_one_ff <= TAP_COUNT_RESET;
        end else if (host_wr_i) begin
            case (host_addr_i)
                ADDR_MODE:        mode_ff     <= host_wdata_i[7:0];
                ADDR_DECIM:       decim_ff    <= host_wdata_i[4:0];
                ADDR_COEF_OFFSET: coef_ofs_ff <= host_wdata_i[7:0];
                ADDR_TAP_COUNT:   tap_count_minus_one_ff <= host_wdata_i[7:0];
                default:          ;
            endcase
        end
    end

    // Sample intake and decimation phase.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_ff  <= 8'h00;
            dcnt_ff    <= 5'h00;
            pending_ff <= 1'b0;
        end else begin
            if (accept) begin
                wr_ptr_ff <= wrap_add(wr_ptr_ff, 9'd1, buf_len);
                dcnt_ff   <= phase_end ? 5'h00 : dcnt_ff + 5'h01;
            end
            if (accept && phase_end) begin
                pending_ff <= 1'b1;
            end else if (start) begin
                pending_ff <= 1'b0;
            end
        end
    end

    // Tap sequencer.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_ff     <= ST_IDLE;
            tap_ff       <= 8'h00;
            coef_addr_ff <= 8'h00;
            data_addr_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff     <= ST_RUN;
                        tap_ff       <= 8'h00;
                        coef_addr_ff <= coef_ofs_ff;
                        data_addr_ff <= oldest;
                    end
                end
                ST_RUN: begin
                    tap_ff       <= tap_ff + 8'd1;
                    coef_addr_ff <= coef_addr_ff + 8'd1;
                    data_addr_ff <= wrap_add(data_addr_ff, channel_count, buf_len);
                    if (run_last) begin
                        state_ff <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (push_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Multiply-accumulate, one cycle behind the memory read.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mac_ff   <= 1'b0;
            last_ff  <= 1'b0;
            push_ff  <= 1'b0;
            acc_i_ff <= '0;
            acc_q_ff <= '0;
        end else begin
            mac_ff  <= state_ff == ST_RUN;
            last_ff <= run_last;
            push_ff <= mac_ff && last_ff;
            if (push_ff) begin
                acc_i_ff <= '0;
                acc_q_ff <= '0;
            end else if (mac_ff) begin
                acc_i_ff <= acc_i_ff + widen(prod_i);
                acc_q_ff <= acc_q_ff + widen(prod_q);
            end
        end
    end

    // The 23 output bits are the top of the accumulator including headroom.
    wire [OUT_W-1:0] res_i = acc_i_ff[ACC_W-1:ACC_W-OUT_W];
    wire [OUT_W-1:0] res_q = acc_q_ff[ACC_W-1:ACC_W-OUT_W];

    // Two-entry output buffer; a full buffer keeps the sequencer from starting.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fcnt_ff   <= 2'd0;
            head_i_ff <= '0;
            head_q_ff <= '0;
            tail_i_ff <= '0;
            tail_q_ff <= '0;
        end else begin
            fcnt_ff <= fcnt_ff + {1'b0, push_ff} - {1'b0, pop};
            if (pop) begin
                head_i_ff <= (fcnt_ff == 2'd2) ? tail_i_ff : res_i;
                head_q_ff <= (fcnt_ff == 2'd2) ? tail_q_ff : res_q;
            end
            if (push_ff && ((fcnt_ff == 2'd0) || (pop && fcnt_ff == 2'd1))) begin
                head_i_ff <= res_i;
                head_q_ff <= res_q;
            end else if (push_ff) begin
                tail_i_ff <= res_i;
                tail_q_ff <= res_q;
            end
        end
    end

    // Host reads: memory contents need two cycles, registers answer alike.
    wire [HOST_W-1:0] reg_rd =
        (rd_addr_ff == ADDR_MODE)        ? {28'h0000000, mode_ff}     :
        (rd_addr_ff == ADDR_DECIM)       ? {31'h0, decim_ff}          :
        (rd_addr_ff == ADDR_COEF_OFFSET) ? {28'h0000000, coef_ofs_ff} :
        (rd_addr_ff == ADDR_TAP_COUNT)   ? {28'h0, tap_count_minus_one_ff} : 36'h000000000;
    wire [HOST_W-1:0] rd_mux =
        (rd_addr_ff[9:8] == ADDR_COEF_BASE[9:8]) ? {16'h0000, coef_q} :
        (rd_addr_ff[9:8] == ADDR_DATA_BASE[9:8]) ? data_q : reg_rd;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_stage_ff  <= 2'b00;
            rd_addr_ff   <= 10'h000;
            host_rdata_o <= '0;
        end else begin
            rd_stage_ff <= {rd_stage_ff[0], host_take && host_rd_i};
            if (host_take && host_rd_i) begin
                rd_addr_ff <= host_addr_i;
            end
            if (rd_stage_ff[0]) begin
                host_rdata_o <= rd_mux;
            end
        end
    end

    // Checks.
    logic [8:0] issued_ff;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || start) begin
            issued_ff <= 9'd0;
        end else if (state_ff == ST_RUN) begin
            issued_ff <= issued_ff + 9'd1;
        end
    end

    sequence s_start;
        start;
    endsequence
    sequence s_run_step;
        (state_ff == ST_RUN) ##1 (state_ff == ST_RUN);
    endsequence
    property p_first_tap;
        s_start |=> (coef_addr_ff == $past(coef_ofs_ff)) && (data_addr_ff == $past(oldest));
    endproperty
    a_first_tap: assert property (p_first_tap) else $error("First tap address wrong");
    property p_coef_walk;
        s_run_step |-> coef_addr_ff == $past(coef_addr_ff) + 8'h01;
    endproperty
    a_coef_walk: assert property (p_coef_walk) else $error("Coefficient address skipped");
    property p_data_walk;
        s_run_step |-> data_addr_ff == wrap_add($past(data_addr_ff), channel_count, buf_len);
    endproperty
    a_data_walk: assert property (p_data_walk) else $error("Sample address step wrong");
    property p_tap_total;
        $fell(state_ff == ST_RUN) |-> issued_ff == tap_count;
    endproperty
    a_tap_total: assert property (p_tap_total) else $error("Wrong number of taps");
    property p_result_clear;
        (mac_ff && last_ff) |=> push_ff ##1 (acc_i_ff == '0 && acc_q_ff == '0 && !push_ff);
    endproperty
    a_result_clear: assert property (p_result_clear) else $error("Accumulator not cleared");
    property p_decim;
        $rose(pending_ff) |-> $past(accept) && $past(phase_end);
    endproperty
    a_decim: assert property (p_decim) else $error("Output trigger off decimation");
    property p_phase_range;
        accept |=> dcnt_ff <= $past(decim_ff);
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("Decimation phase too far");
    property p_store;
        accept |=> wr_ptr_ff == wrap_add($past(wr_ptr_ff), 9'h001, $past(buf_len));
    endproperty
    a_store: assert property (p_store) else $error("Write pointer failed to advance");
    property p_no_overflow;
        push_ff |-> (fcnt_ff != 2'h2) || pop;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("Output buffer overflow");
    property p_buf_len;
        s_start |-> !buf_len[0] && (buf_len >= span) && (span != 9'h000);
    endproperty
    a_buf_len: assert property (p_buf_len) else $error("Buffer length not even");

endmodule : fir_stage

`default_nettype wire

// ==== verif/comb_source_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module comb_source_model #(
    parameter int GAP = 10
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Sample stream
    input  wire logic        in_ready_i,
    output logic             valid_o,
    output logic      [17:0] i_o,
    output logic      [17:0] q_o
);
    logic [35:0] pend[$];

    task automatic push(input logic [35:0] w);
        pend.push_back(w);
    endtask : push

    // Samples stay GAP cycles apart so the tap walk fits the clock budget.
    initial begin
        valid_o = 1'b0;
        i_o = 18'h00000;
        q_o = 18'h00000;
        forever begin
            @(posedge sys_clk_i);
            if (!reset_i && pend.size() > 0) begin
                valid_o <= 1'b1;
                {q_o, i_o} <= pend[0];
                do @(posedge sys_clk_i); while (in_ready_i !== 1'b1);
                void'(pend.pop_front());
                valid_o <= 1'b0;
                {q_o, i_o} <= ~{q_o, i_o};
                repeat (GAP - 2) @(posedge sys_clk_i);
            end
        end
    end
endmodule : comb_source_model

`default_nettype wire

// ==== verif/ram_coefficient_decimating_fir_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module ram_coefficient_decimating_fir_tb;
    import fir_pkg::*;
    logic                sys_clk_i;
    logic                reset_i;
    logic                in_valid;
    logic                in_ready;
    logic [SAMPLE_W-1:0] in_i;
    logic [SAMPLE_W-1:0] in_q;
    logic                out_valid;
    logic                out_ready;
    logic [OUT_W-1:0]    out_i;
    logic [OUT_W-1:0]    out_q;
    logic [9:0]          host_addr;
    logic                host_wr;
    logic                host_rd;
    logic [HOST_W-1:0]   host_wdata;
    logic                host_ready;
    logic                host_rvalid;
    logic [HOST_W-1:0]   host_rdata;
    logic [19:0]         coef_mem [0:255];
    logic [35:0]         hist[$];
    logic [45:0]         got[$];
    logic [45:0]         exp_q[$];
    int                  n_fail = 0;
    int                  checks = 0;
    int                  seq = 0;
    int                  ph = 0;
    int                  ratio = 1;
    int                  taps = 1;
    int                  ofs = 0;
    int                  chans = 1;

    fir_stage fir_stage_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .in_valid_i(in_valid),
        .in_ready_o(in_ready), .in_i_i(in_i), .in_q_i(in_q), .out_valid_o(out_valid),
        .out_ready_i(out_ready), .out_i_o(out_i), .out_q_o(out_q), .host_addr_i(host_addr),
        .host_wr_i(host_wr), .host_rd_i(host_rd), .host_wdata_i(host_wdata),
        .host_ready_o(host_ready), .host_rvalid_o(host_rvalid), .host_rdata_o(host_rdata));

    comb_source_model comb_source_model_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .in_ready_i(in_ready), .valid_o(in_valid), .i_o(in_i), .q_o(in_q));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back({out_q, out_i});
        end
    end

    task automatic check(input logic [45:0] seen, input logic [45:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic host_write(input logic [9:0] a, input logic [35:0] d);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        do @(posedge sys_clk_i); while (host_ready !== 1'b1);
        host_wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask : host_write

    task automatic rd_check(input logic [9:0] a, input logic [35:0] exp);
        logic [35:0] d;
        d = 'x;
        host_addr <= a;
        host_rd <= 1'b1;
        do @(posedge sys_clk_i); while (host_ready !== 1'b1);
        host_rd <= 1'b0;
        repeat (3) begin
            @(posedge sys_clk_i);
            if (host_rvalid === 1'b1) d = host_rdata;
        end
        check(46'(d), 46'(exp), "register read");
    endtask : rd_check

    // Window of the newest taps*chans samples, every chans-th one, oldest against the offset coefficient.
    function automatic logic [45:0] expect_word();
        logic signed [47:0] ai;
        logic signed [47:0] aq;
        logic [35:0] w;
        ai = '0;
        aq = '0;
        for (int k = 0; k < taps; k++) begin
            w = hist[hist.size() - taps * chans + k * chans];
            ai += $signed(coef_mem[(ofs + k) % 256]) * $signed(w[17:0]);
            aq += $signed(coef_mem[(ofs + k) % 256]) * $signed(w[35:18]);
        end
        return {aq[40:18], ai[40:18]};
    endfunction : expect_word

    task automatic cfg(input int r, input int t, input int o);
        ratio = r;
        taps = t;
        ofs = o;
        ph = 0;
        host_write(ADDR_DECIM, 36'(r - 1));
        host_write(ADDR_TAP_COUNT, 36'(t - 1));
        host_write(ADDR_COEF_OFFSET, 36'(o));
    endtask : cfg

    task automatic stream(input int n);
        logic [17:0] s;
        for (int k = 0; k < n; k++) begin
            s = 18'((seq * 7919) & 32'h1ffff);
            seq++;
            hist.push_back({~s, s});
            comb_source_model_i.push({~s, s});
            ph++;
            if (ph == ratio) begin
                ph = 0;
                exp_q.push_back(expect_word());
            end
        end
    endtask : stream

    task automatic drain(input int n);
        int w;
        w = 0;
        while (got.size() < n && w < 3000) begin
            @(posedge sys_clk_i);
            w++;
        end
        repeat (30) @(posedge sys_clk_i);
        check(46'(got.size()), 46'(n), "output count");
        foreach (exp_q[k]) check(got[k], exp_q[k], "filter output");
        got.delete();
        exp_q.delete();
    endtask : drain

    task automatic t_regs;
        rd_check(ADDR_COEF_OFFSET, 36'h0);
        rd_check(ADDR_TAP_COUNT, 36'h0);
        host_write(ADDR_MODE, 36'h2);
        rd_check(ADDR_MODE, 36'h2);
        host_write(ADDR_MODE, 36'h0);
        host_write(ADDR_DECIM, 36'h1f);
        rd_check(ADDR_DECIM, 36'h1f);
        host_write(10'h200, 36'h5);
        rd_check(10'h200, 36'h0);
    endtask : t_regs

    task automatic t_rams;
        for (int a = 0; a < 256; a++) begin
            coef_mem[a] = 20'((a * 48611 + 77) & 32'hfffff);
            host_write(10'(a), 36'(coef_mem[a]));
        end
        rd_check(ADDR_COEF_BASE, 36'(coef_mem[0]));
        rd_check(ADDR_COEF_LAST, 36'(coef_mem[255]));
        host_write(ADDR_DATA_LAST, 36'h9abcd1234);
        rd_check(ADDR_DATA_LAST, 36'h9abcd1234);
        cfg(4, 4, 0);
        for (int a = 0; a < 4; a++) begin
            host_write(ADDR_DATA_BASE + 10'(a), 36'h0);
            hist.push_back(36'h0);
        end
    endtask : t_rams

    // Both results of a full buffer must survive while the input is held off.
    task automatic t_stall;
        cfg(1, 4, 0);
        out_ready <= 1'b0;
        stream(6);
        repeat (120) @(posedge sys_clk_i);
        check(46'(out_valid), 46'h1, "held output");
        check(46'(in_ready), 46'h0, "input while full");
        out_ready <= 1'b1;
        drain(6);
    endtask : t_stall

    // Odd tap count, then dual-channel stepping; both keep a four-location buffer.
    task automatic t_odd_dual;
        cfg(2, 3, 5);
        stream(4);
        drain(2);
        host_write(ADDR_MODE, 36'h2);
        chans = 2;
        cfg(2, 2, 8);
        stream(4);
        drain(2);
        host_write(ADDR_MODE, 36'h0);
        chans = 1;
    endtask : t_odd_dual

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        report_and_stop();
    end

    initial begin
        reset_i = 1'b1;
        host_addr = 10'h000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 36'h0;
        out_ready = 1'b1;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        t_regs();
        t_rams();
        stream(8);
        drain(2);
        cfg(4, 4, 16);
        stream(4);
        drain(1);
        cfg(32, 4, 254);
        stream(64);
        drain(2);
        t_stall();
        t_odd_dual();
        report_and_stop();
    end
endmodule : ram_coefficient_decimating_fir_tb

`default_nettype wire
